// >>> src/bpcfg_regs.sv
// buffer pointer, indirect select and configuration registers over AXI4-Lite
// assumes one clock MCLK, synchronous SRST, same-domain bus master
`timescale 1ns/10ps
`include "bpcfg_consts.svh"

module bpcfg_regs
   import bpcfg_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        SRST,
   input  wire logic [5:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [5:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic [7:0]  RAM_RDATA,
   output logic [10:0]      RAM_ADDR,
   output logic [7:0]       RAM_WDATA,
   output logic             RAM_WE,
   output logic             SOFT_RESET,
   output logic             CHAINING_EN
);

   // bus capture state
   logic [5:0]  awaddr_r;
   logic        aw_held_r;
   logic [7:0]  wdata_r;
   logic        wlane_r;
   logic        w_held_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;

   // register storage
   logic        access_direction_r;
   logic        pointer_advance_en_r;
   logic [2:0]  ptr_upper_bits_r;
   logic [7:0]  ptr_lower_bits_r;
   logic        sel2_r;
   logic [7:0]  config_r;
   logic [7:0]  ind_r [0:4];
   logic [7:0]  status_r;
   logic [7:0]  diag_r;
   logic        ram_we_r;
   logic [7:0]  ram_wdata_r;

   // write path: fires once both address and data are held
   wire         wr_fire  = aw_held_r && w_held_r && !bvalid_r;
   wire         wr_en    = wr_fire && wlane_r;
   wire         wr_hi    = wr_en && (awaddr_r == `BPCFG_OFS_PTR_HIGH);
   wire         wr_lo    = wr_en && (awaddr_r == `BPCFG_OFS_PTR_LOW);
   wire         wr_sel   = wr_en && (awaddr_r == `BPCFG_OFS_IND_SEL);
   wire         wr_cfg   = wr_en && (awaddr_r == `BPCFG_OFS_CONFIG);
   wire         wr_data  = wr_en && (awaddr_r == `BPCFG_OFS_RAM_DATA);
   wire         wr_ind   = wr_en && (awaddr_r == `BPCFG_OFS_INDIRECT);
   wire         wr_known = (awaddr_r == `BPCFG_OFS_PTR_HIGH) || (awaddr_r == `BPCFG_OFS_PTR_LOW)
                        || (awaddr_r == `BPCFG_OFS_IND_SEL) || (awaddr_r == `BPCFG_OFS_CONFIG)
                        || (awaddr_r == `BPCFG_OFS_RAM_DATA) || (awaddr_r == `BPCFG_OFS_INDIRECT)
                        || (awaddr_r == `BPCFG_OFS_STATUS);

   // read path: single cycle decode, answered the edge after arvalid
   wire         rd_fire  = S_AXI_ARVALID && !rvalid_r;
   wire         rd_data  = rd_fire && (S_AXI_ARADDR == `BPCFG_OFS_RAM_DATA);

   // low select bits shared with config
   wire [2:0]   ind_sel  = {sel2_r, config_r[1:0]};
   wire         ind_ok   = ind_sel <= 3'(BPCFG_SEL_SETUP2);

   wire [7:0]   ind_rdata = ind_ok ? ind_r[ind_sel] : 8'h00;
   wire         ind_wr_ok = wr_ind && ind_ok && (ind_sel != 3'(BPCFG_SEL_NEXT_ID));

   wire         soft_rst = config_r[`BPCFG_BIT_SWRST];

   // advance after access; a write steps once its strobe has used the old address
   wire         data_acc = access_direction_r ? rd_data : ram_we_r;
   wire         ptr_step = data_acc && pointer_advance_en_r;
   wire [10:0]  ptr_nxt  = {ptr_upper_bits_r, ptr_lower_bits_r} + 11'h001;

   logic [7:0]  rd_byte;
   logic        rd_known;

   // read multiplexer
   always_comb
   begin
      rd_byte  = 8'h00;
      rd_known = 1'b1;
      case (S_AXI_ARADDR)
         `BPCFG_OFS_PTR_HIGH: rd_byte = {access_direction_r, pointer_advance_en_r,
                                         3'h0, ptr_upper_bits_r};
         `BPCFG_OFS_PTR_LOW:  rd_byte = ptr_lower_bits_r;
         `BPCFG_OFS_IND_SEL:  rd_byte = {5'h00, ind_sel};
         `BPCFG_OFS_CONFIG:   rd_byte = config_r;
         // reads of data while in write direction return zero
         `BPCFG_OFS_RAM_DATA: rd_byte = access_direction_r ? RAM_RDATA : 8'h00;
         `BPCFG_OFS_INDIRECT: rd_byte = ind_rdata;
         `BPCFG_OFS_STATUS:   rd_byte = status_r;
         default:             rd_known = 1'b0;
      endcase
   end

   // axi write channel capture and response
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= 6'h00;
         wdata_r   <= 8'h00;
         wlane_r   <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `BPCFG_RESP_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && !aw_held_r)
         begin
            aw_held_r <= 1'b1;
            awaddr_r  <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && !w_held_r)
         begin
            w_held_r <= 1'b1;
            wdata_r  <= S_AXI_WDATA[7:0];
            wlane_r  <= S_AXI_WSTRB[0];
         end
         if (wr_fire)
         begin
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_known ? `BPCFG_RESP_OKAY : `BPCFG_RESP_SLVERR;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
         end
         else if (bvalid_r && S_AXI_BREADY)
            bvalid_r <= 1'b0;
      end
   end

   // axi read channel
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= `BPCFG_RESP_OKAY;
      end
      else if (rd_fire)
      begin
         rvalid_r <= 1'b1;
         rdata_r  <= {24'h00_0000, rd_byte};
         rresp_r  <= rd_known ? `BPCFG_RESP_OKAY : `BPCFG_RESP_SLVERR;
      end
      else if (rvalid_r && S_AXI_RREADY)
         rvalid_r <= 1'b0;
   end

   // pointer registers; a pointer write wins over an auto step for the byte it writes, the other byte still steps
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         access_direction_r   <= 1'b0;
         pointer_advance_en_r <= 1'b0;
         ptr_upper_bits_r     <= 3'h0;
         ptr_lower_bits_r     <= `BPCFG_RST_BYTE;
      end
      else
      begin
         if (wr_hi)
         begin
            access_direction_r   <= wdata_r[`BPCFG_BIT_DIR];
            pointer_advance_en_r <= wdata_r[`BPCFG_BIT_ADV];
            ptr_upper_bits_r     <= wdata_r[2:0];
         end
         else if (ptr_step)
            ptr_upper_bits_r <= ptr_nxt[10:8];
         if (wr_lo)
            ptr_lower_bits_r <= wdata_r;
         else if (ptr_step)
            ptr_lower_bits_r <= ptr_nxt[7:0];
      end
   end

   // configuration and select; soft reset never touches these
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         config_r <= `BPCFG_RST_BYTE;
         sel2_r   <= 1'b0;
      end
      else if (wr_cfg)
      begin
         config_r <= wdata_r;
         sel2_r   <= 1'b0;
      end
      else if (wr_sel)
      begin
         config_r[1:0] <= wdata_r[1:0];
         sel2_r        <= wdata_r[`BPCFG_BIT_SEL2];
      end
   end

   // indirect registers; next id is hardware owned and read only here
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         for (int i = 0; i < 5; i++)
            ind_r[i] <= `BPCFG_RST_BYTE;
         status_r <= `BPCFG_RST_STATUS;
         diag_r   <= `BPCFG_RST_DIAG;
      end
      else
      begin
         if (ind_wr_ok)
            ind_r[ind_sel] <= wdata_r;
         if (soft_rst)
         begin
            status_r                  <= `BPCFG_RST_STATUS;
            diag_r                    <= `BPCFG_RST_DIAG;
            ind_r[BPCFG_SEL_NEXT_ID]  <= `BPCFG_RST_NEXT_ID;
         end
      end
   end

   // ram write strobe registered with its data
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         ram_we_r    <= 1'b0;
         ram_wdata_r <= 8'h00;
      end
      else
      begin
         ram_we_r    <= wr_data && !access_direction_r;
         ram_wdata_r <= wdata_r;
      end
   end

   assign S_AXI_AWREADY = !aw_held_r;
   assign S_AXI_WREADY  = !w_held_r;
   assign S_AXI_BVALID  = bvalid_r;
   assign S_AXI_BRESP   = bresp_r;
   assign S_AXI_ARREADY = !rvalid_r;
   assign S_AXI_RVALID  = rvalid_r;
   assign S_AXI_RDATA   = rdata_r;
   assign S_AXI_RRESP   = rresp_r;
   assign RAM_ADDR      = {ptr_upper_bits_r, ptr_lower_bits_r};
   assign RAM_WE        = ram_we_r;
   assign RAM_WDATA     = ram_wdata_r;
   assign SOFT_RESET    = soft_rst;
   assign CHAINING_EN   = config_r[`BPCFG_BIT_CHAIN];

endmodule

// >>> src/bpcfg_consts.svh
// register offsets, field positions and reset values of the pointer/config bank
// assumes a 32-bit AXI4-Lite slave with one register per aligned word
`ifndef BPCFG_CONSTS_SVH
`define BPCFG_CONSTS_SVH

`define BPCFG_OFS_PTR_HIGH    6'h00
`define BPCFG_OFS_PTR_LOW     6'h04
`define BPCFG_OFS_IND_SEL     6'h08
`define BPCFG_OFS_CONFIG      6'h0c
`define BPCFG_OFS_RAM_DATA    6'h10
`define BPCFG_OFS_INDIRECT    6'h14
`define BPCFG_OFS_STATUS      6'h18

`define BPCFG_BIT_DIR         7
`define BPCFG_BIT_ADV         6
`define BPCFG_BIT_SWRST       7
`define BPCFG_BIT_CHAIN       6
`define BPCFG_BIT_SEL2        2

`define BPCFG_RST_BYTE        8'h00
`define BPCFG_RST_STATUS      8'h91
`define BPCFG_RST_NEXT_ID     8'h00
`define BPCFG_RST_DIAG        8'h00
`define BPCFG_RESP_OKAY       2'b00
`define BPCFG_RESP_SLVERR     2'b10

`endif

// >>> src/bpcfg_pkg.sv
// types shared by the pointer/config register bank
// assumes the constants header is included by the design file
package bpcfg_pkg;
   typedef enum logic [2:0] {
      BPCFG_SEL_TENT_ID,
      BPCFG_SEL_NODE_ID,
      BPCFG_SEL_SETUP1,
      BPCFG_SEL_NEXT_ID,
      BPCFG_SEL_SETUP2,
      BPCFG_SEL_RSV5,
      BPCFG_SEL_RSV6,
      BPCFG_SEL_RSV7
   } bpcfg_sel_t;
endpackage

// >>> test/bpcfg_ram_model.sv
// behavioural buffer RAM standing behind the pointer bank
// assumes combinational read and a one-cycle write strobe
`timescale 1ns/10ps
module bpcfg_ram_model
(
   input  wire logic        clk,
   input  wire logic [10:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        we,
   output logic [7:0]       rdata
);
   logic [7:0] mem [2048];
   // zero-filled so a read never hands back an unknown byte
   initial
      foreach (mem[i])
         mem[i] = 8'h00;
   always @(posedge clk)
      if (we)
         mem[addr] <= wdata;
   assign rdata = mem[addr];
endmodule

// >>> test/bpcfg_checker.sv
// assertions on the ports of the pointer/config bank
// assumes it is bound to bpcfg_regs and sees only its ports
`timescale 1ns/10ps
`include "bpcfg_consts.svh"
module bpcfg_checker
(
   input wire logic        MCLK,
   input wire logic        SRST,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        RAM_WE,
   input wire logic [10:0] RAM_ADDR,
   input wire logic        SOFT_RESET,
   input wire logic        CHAINING_EN
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);
   // outputs move only as the result of a finished bus access
   a_bresp_held: assert property (
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped early");
   a_rdata_byte: assert property (
      S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
      else $error("read data above bit 7 not zero");
   a_we_pulse: assert property (RAM_WE |=> !RAM_WE)
      else $error("ram strobe longer than one cycle");
   a_we_after_write: assert property (RAM_WE |-> $rose(S_AXI_BVALID))
      else $error("ram strobe without a write");
   a_ptr_on_access: assert property (
      $changed(RAM_ADDR) |-> $rose(S_AXI_BVALID) || $rose(S_AXI_RVALID) || $past(RAM_WE))
      else $error("pointer moved without an access");
   a_ptr_swrst: assert property ($rose(SOFT_RESET) |-> $stable(RAM_ADDR))
      else $error("soft reset disturbed the pointer");
   a_swrst_write: assert property ($changed(SOFT_RESET) |-> $rose(S_AXI_BVALID))
      else $error("soft reset changed without a write");
   a_chain_write: assert property (
      $changed(CHAINING_EN) |-> $rose(S_AXI_BVALID) && S_AXI_BRESP == `BPCFG_RESP_OKAY)
      else $error("chaining enable changed without a write");
endmodule
bind bpcfg_regs bpcfg_checker u_chk (.*);

// >>> test/ram_pointer_and_config_regs_tb.sv
// self-checking bench for the pointer/config bank over AXI4-Lite
// assumes the RAM model behind the bank and the bound checker
`timescale 1ns/10ps
`include "bpcfg_consts.svh"
module ram_pointer_and_config_regs_tb;
   logic        MCLK = 1'h0, SRST = 1'h1, S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0;
   logic        S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
   logic [5:0]  S_AXI_AWADDR = 6'h00, S_AXI_ARADDR = 6'h00;
   logic [31:0] S_AXI_WDATA = 32'h0;
   logic [3:0]  S_AXI_WSTRB = 4'hf;
   logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic        RAM_WE, SOFT_RESET, CHAINING_EN;
   logic [31:0] S_AXI_RDATA;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   logic [7:0]  RAM_RDATA, RAM_WDATA;
   logic [10:0] RAM_ADDR;
   int          failures = 0, check_count = 0, cycles = 0;
   localparam logic [5:0] HI = `BPCFG_OFS_PTR_HIGH, LO = `BPCFG_OFS_PTR_LOW;
   localparam logic [5:0] SEL = `BPCFG_OFS_IND_SEL, CFG = `BPCFG_OFS_CONFIG;
   localparam logic [5:0] DAT = `BPCFG_OFS_RAM_DATA, IND = `BPCFG_OFS_INDIRECT;

   bpcfg_regs dut (.*);
   bpcfg_ram_model u_ram (.clk(MCLK), .addr(RAM_ADDR), .wdata(RAM_WDATA), .we(RAM_WE),
      .rdata(RAM_RDATA));

   always #50 MCLK = ~MCLK;

   task automatic test_done();
      if (failures == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // a hang ends the run long after the tests should have finished
   always @(posedge MCLK)
   begin
      cycles = cycles + 1;
      if (cycles == 4000)
      begin
         failures = failures + 1;
         test_done();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [5:0] a, input logic [7:0] d,
      input logic [1:0] r = `BPCFG_RESP_OKAY);
      @(posedge MCLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= {24'h000000, d};
      S_AXI_AWVALID <= 1'h1;
      S_AXI_WVALID <= 1'h1;
      S_AXI_BREADY <= 1'h1;
      do
      begin
         @(posedge MCLK);
         if (S_AXI_AWREADY)
            S_AXI_AWVALID <= 1'h0;
         if (S_AXI_WREADY)
            S_AXI_WVALID <= 1'h0;
      end
      while (S_AXI_BVALID !== 1'h1);
      S_AXI_BREADY <= 1'h0;
      chk("bresp", {30'h0, r}, {30'h0, S_AXI_BRESP});
      @(negedge MCLK);
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] d,
      input logic [1:0] r = `BPCFG_RESP_OKAY);
      @(posedge MCLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'h1;
      S_AXI_RREADY <= 1'h1;
      do
      begin
         @(posedge MCLK);
         if (S_AXI_ARREADY)
            S_AXI_ARVALID <= 1'h0;
      end
      while (S_AXI_RVALID !== 1'h1);
      S_AXI_RREADY <= 1'h0;
      chk("rdata", {24'h000000, d}, S_AXI_RDATA);
      chk("rresp", {30'h0, r}, {30'h0, S_AXI_RRESP});
      @(negedge MCLK);
   endtask

   initial
   begin
      repeat (16) @(posedge MCLK);
      SRST <= 1'h0;
      // hard reset values, read-only status and unmapped words
      for (int i = 0; i < 4; i++)
         rd(6'(4 * i), `BPCFG_RST_BYTE);
      wr(`BPCFG_OFS_STATUS, 8'h00);
      rd(`BPCFG_OFS_STATUS, `BPCFG_RST_STATUS);
      rd(6'h1c, 8'h00, `BPCFG_RESP_SLVERR);
      wr(6'h3c, 8'hff, `BPCFG_RESP_SLVERR);
      // write with advance crosses from the low byte into the high one
      wr(HI, 8'h45);
      wr(LO, 8'hff);
      chk("ram_addr", 32'h5ff, {21'h0, RAM_ADDR});
      wr(DAT, 8'h3c);
      chk("ram_addr", 32'h600, {21'h0, RAM_ADDR});
      wr(HI, 8'hc5);
      wr(LO, 8'hff);
      rd(DAT, 8'h3c);
      rd(DAT, 8'h00);
      rd(LO, 8'h01);
      // no advance: pointer holds; wrong direction gives no data
      wr(HI, 8'h06);
      rd(DAT, 8'h00);
      wr(DAT, 8'h5a);
      wr(HI, 8'h86);
      rd(DAT, 8'h5a);
      chk("ram_addr", 32'h601, {21'h0, RAM_ADDR});
      // every select code, then a config write clears the top select bit
      for (int i = 0; i < 8; i++)
      begin
         wr(SEL, 8'(i));
         rd(SEL, 8'(i));
      end
      wr(CFG, 8'h41);
      rd(SEL, 8'h01);
      chk("chaining_en", 32'h1, {31'h0, CHAINING_EN});
      wr(IND, 8'h2a);
      rd(IND, 8'h2a);
      wr(SEL, 8'h03);
      wr(IND, 8'h77);
      rd(IND, `BPCFG_RST_NEXT_ID);
      // soft reset spares pointer and config and holds until released
      wr(CFG, 8'hc3);
      rd(CFG, 8'hc3);
      rd(LO, 8'h01);
      rd(`BPCFG_OFS_STATUS, `BPCFG_RST_STATUS);
      chk("soft_reset", 32'h1, {31'h0, SOFT_RESET});
      wr(CFG, 8'h03);
      chk("soft_reset", 32'h0, {31'h0, SOFT_RESET});
      chk("chaining_en", 32'h0, {31'h0, CHAINING_EN});
      test_done();
   end
endmodule
